// [common/kra_pkg.sv]
`default_nettype none
package kra_pkg;

    ////////////////////////////////////////////////////////////////////////
    // geometry
    localparam int KRA_NSRC   = 16;
    localparam int KRA_IDX_W  = 4;
    localparam int KRA_NKEY   = 6;
    localparam int KRA_ADDR_W = 18;
    localparam int KRA_KEY_SRC = 13;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [15:0] KRA_IDX_IF0 = 16'hFFE0;
    localparam logic [15:0] KRA_IDX_IF1 = 16'hFFE1;
    localparam logic [15:0] KRA_IDX_PSW = 16'hFFE2;
    localparam logic [15:0] KRA_IDX_MK0 = 16'hFFE4;
    localparam logic [15:0] KRA_IDX_MK1 = 16'hFFE5;
    localparam logic [15:0] KRA_IDX_PR0 = 16'hFFE8;
    localparam logic [15:0] KRA_IDX_PR1 = 16'hFFE9;
    localparam logic [15:0] KRA_IDX_KRS = 16'hFFF5;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] KRA_RST_FLAGS = 8'h00;
    localparam logic [7:0] KRA_RST_MASK  = 8'hFF;
    localparam logic [7:0] KRA_RST_PRIO  = 8'hFF;
    localparam logic [7:0] KRA_RST_PSW   = 8'h02;
    localparam logic [7:0] KRA_RST_KRS   = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // field layouts
    localparam int         KRA_PSW_IE    = 7;
    localparam logic [7:0] KRA_PSW_WMASK = 8'hD1;
    localparam logic [7:0] KRA_PSW_FIXED = 8'h02;
    localparam int         KRA_KRS_GRP   = 0;
    localparam int         KRA_KRS_P4    = 4;
    localparam int         KRA_KRS_P5    = 5;
    localparam logic [7:0] KRA_KRS_WMASK = 8'h31;

    ////////////////////////////////////////////////////////////////////////
    // vector table
    localparam logic [15:0] KRA_VEC_NMI  = 16'h0002;
    localparam logic [15:0] KRA_VEC_BASE = 16'h0004;

    typedef enum logic [3:0] {
        KRA_ST_IDLE = 4'b0001,
        KRA_ST_PSW  = 4'b0010,
        KRA_ST_PC   = 4'b0100,
        KRA_ST_VEC  = 4'b1000
    } kra_state_type;

endpackage
`default_nettype wire

// [common/kra_key_if.sv]
`default_nettype none
interface kra_key_if;
    import kra_pkg::*;
    logic [KRA_NKEY-1:0] keyEnable;
    logic                keyEvent;
    modport det (input keyEnable, output keyEvent);
    modport ctl (output keyEnable, input keyEvent);
endinterface
`default_nettype wire

// [hw/kra_key_edge.sv]
`default_nettype none
module kra_key_edge
    import kra_pkg::*;
(
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire logic [KRA_NKEY-1:0] keyInput,
    kra_key_if.det                   keyBus
);

    logic [KRA_NKEY-1:0] syncA;
    logic [KRA_NKEY-1:0] syncB;
    logic                allHigh;
    logic                allHighPrev;
    logic                keyEvent;

    // two-stage synchroniser, reset high so release makes no false edge
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            syncA <= '1;
            syncB <= '1;
        end else begin
            syncA <= keyInput;
            syncB <= syncA;
        end
    end

    // unselected pins count as high; one low selected pin blocks others
    assign allHigh = &(syncB | ~keyBus.keyEnable);

    // falling edge of the combined level, one pulse per edge
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            allHighPrev <= 1'b1;
            keyEvent    <= 1'b0;
        end else begin
            allHighPrev <= allHigh;
            keyEvent    <= allHighPrev & ~allHigh;
        end
    end

    assign keyBus.keyEvent = keyEvent;

endmodule
`default_nettype wire

// [hw/kra_prio_pick.sv]
`default_nettype none
module kra_prio_pick
    import kra_pkg::*;
#(
    parameter int NSRC = KRA_NSRC,
    parameter int IW   = KRA_IDX_W
) (
    input  wire logic [NSRC-1:0] pending,
    input  wire logic [NSRC-1:0] lowPrio,
    output logic                 found,
    output logic [IW-1:0]        index
);

    logic [NSRC-1:0] hiCand;
    logic [NSRC-1:0] loCand;
    logic [NSRC:0]   hiSeen;
    logic [NSRC:0]   loSeen;
    logic [NSRC-1:0] hiOne;
    logic [NSRC-1:0] loOne;

    // per source: split by priority flag, keep the lowest index of each
    assign hiSeen[0] = 1'b0;
    assign loSeen[0] = 1'b0;
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : gSrc
            assign hiCand[g]   = pending[g] & ~lowPrio[g];
            assign loCand[g]   = pending[g] & lowPrio[g];
            assign hiOne[g]    = hiCand[g] & ~hiSeen[g];
            assign loOne[g]    = loCand[g] & ~loSeen[g];
            assign hiSeen[g+1] = hiSeen[g] | hiCand[g];
            assign loSeen[g+1] = loSeen[g] | loCand[g];
        end
    endgenerate

    // high group beats low group, then the lower index wins
    always_comb begin
        found = hiSeen[NSRC] | loSeen[NSRC];
        index = '0;
        for (int i = 0; i < NSRC; i++) begin
            if (hiSeen[NSRC] ? hiOne[i] : loOne[i]) begin
                index = IW'(i);
            end
        end
    end

endmodule
`default_nettype wire

// [hw/kra_key_intc.sv]
// Contract
// - select bit 0 enables key pins 0-3 together; bits 4, 5 pins 4, 5
// - key select register resets to zero, no pin detects after reset
// - select bit 0 means off, 1 means falling-edge detection
// - pull-up on for selected key pins, off when pin is an output
// - no key request while any selected key pin is low
// - non-maskable request ignores enable and beats every other request
// - non-maskable accept pushes status, then PC, clears enable, vectors
// - a new non-maskable request interrupts a running non-maskable one
// - maskable accepted only if flag set, mask clear, enable set
// - maskable service starts 9 to 19 CPU clocks after request
// - simultaneous maskable requests taken by priority flag, highest first
// - requests not yet acceptable stay pending until acceptable
// - maskable accept pushes status, PC, clears enable, own vector
// - flag set by clock n-1 is taken after this instruction, else next
// - no acceptance while an instruction touches flag or mask registers
// - no maskable nesting unless enable is set again by software
// - mask flag 0 enables servicing, 1 disables it
// - accepted request flag is cleared before the routine starts
// - global enable is status word top bit, cleared by reset
`default_nettype none
module kra_key_intc
    import kra_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    // key pins
    input  wire logic [KRA_NKEY-1:0]  keyInput,
    input  wire logic [KRA_NKEY-1:0]  portOutputMode,
    output logic      [KRA_NKEY-1:0]  keyPullUp,
    // request sources
    input  wire logic [KRA_NSRC-1:0]  periphRequest,
    input  wire logic                 nmiRequest,
    // CPU sequencer
    input  wire logic                 instrLastClock,
    input  wire logic                 instrFlagAccess,
    input  wire logic                 enableInstr,
    input  wire logic                 disableInstr,
    input  wire logic                 returnFromService,
    input  wire logic [7:0]           restorePsw,
    input  wire logic [15:0]          cpuPc,
    output logic                      stackPush,
    output logic [15:0]               stackData,
    output logic                      vectorLoad,
    output logic [15:0]               vectorAddr
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    kra_key_if keyBus ();

    logic [KRA_NSRC-1:0]  reqFlags;
    logic [KRA_NSRC-1:0]  maskFlags;
    logic [KRA_NSRC-1:0]  prioFlags;
    logic [7:0]           programStatusWord;
    logic [7:0]           keySelect;
    logic [KRA_NSRC-1:0]  next_reqFlags;
    logic [KRA_NSRC-1:0]  setVec;
    logic [KRA_NSRC-1:0]  pendMask;
    logic                 found;
    logic [KRA_IDX_W-1:0] pickIdx;
    logic                 nmiPending;
    logic                 acceptWindow;
    logic                 acceptNmi;
    logic                 acceptMask;
    logic                 globalEnable;
    kra_state_type        state;
    kra_state_type        next_state;
    logic [7:0]           savedPsw;
    logic [15:0]          vecTarget;
    logic                 wrPend;
    logic [15:0]          wrIdx;
    logic                 addrPhase;
    logic                 addrOk;
    logic [15:0]          addrIdx;
    logic                 flagRegWrite;
    logic [7:0]           wrByte;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite address decode and data phase

    assign addrPhase = hsel & htrans[1] & hready;
    assign addrIdx   = haddr[KRA_ADDR_W-1:2];
    // only aligned words inside the 18-bit window decode
    assign addrOk    = (haddr[31:KRA_ADDR_W] == '0) & (haddr[1:0] == 2'h0);
    assign wrByte    = hwdata[7:0];

    // capture a write address; the data follows in the next cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wrPend <= 1'b0;
            wrIdx  <= 16'h0000;
        end else begin
            wrPend <= addrPhase & hwrite & addrOk;
            wrIdx  <= addrIdx;
        end
    end

    // zero wait states, always OKAY
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read data registered at the address phase; unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase & ~hwrite) begin
            hrdata <= 32'h0000_0000;
            if (addrOk) begin
                unique case (addrIdx)
                    KRA_IDX_IF0: hrdata[7:0] <= reqFlags[7:0];
                    KRA_IDX_IF1: hrdata[7:0] <= reqFlags[15:8];
                    KRA_IDX_MK0: hrdata[7:0] <= maskFlags[7:0];
                    KRA_IDX_MK1: hrdata[7:0] <= maskFlags[15:8];
                    KRA_IDX_PR0: hrdata[7:0] <= prioFlags[7:0];
                    KRA_IDX_PR1: hrdata[7:0] <= prioFlags[15:8];
                    KRA_IDX_PSW: hrdata[7:0] <= programStatusWord;
                    KRA_IDX_KRS: hrdata[7:0] <= keySelect;
                    default:     hrdata[7:0] <= 8'h00;
                endcase
            end
        end
    end

    // a flag or mask register write in flight holds acceptance off
    assign flagRegWrite = wrPend & ((wrIdx == KRA_IDX_IF0) |
                                    (wrIdx == KRA_IDX_IF1) |
                                    (wrIdx == KRA_IDX_MK0) |
                                    (wrIdx == KRA_IDX_MK1));

    ////////////////////////////////////////////////////////////////////////
    // key return select and pull-up control

    // undefined bits are dropped, so they always read zero
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            keySelect <= KRA_RST_KRS;
        end else if (wrPend & (wrIdx == KRA_IDX_KRS)) begin
            keySelect <= wrByte & KRA_KRS_WMASK;
        end
    end

    // group bit covers the four lowest pins at once
    assign keyBus.keyEnable = {keySelect[KRA_KRS_P5],
                               keySelect[KRA_KRS_P4],
                               {4{keySelect[KRA_KRS_GRP]}}};

    // pull-up follows selection one cycle late and drops one cycle after a pin turns output
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            keyPullUp <= '0;
        end else begin
            keyPullUp <= keyBus.keyEnable & ~portOutputMode;
        end
    end

    kra_key_edge u_key_edge (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .keyInput (keyInput),
        .keyBus   (keyBus.det)
    );

    ////////////////////////////////////////////////////////////////////////
    // request, mask and priority flags

    // the key detector owns its request bit; the peripheral line is unused
    always_comb begin
        setVec              = periphRequest;
        setVec[KRA_KEY_SRC] = keyBus.keyEvent;
    end

    // order: software write, accept clear, then hardware set wins
    always_comb begin
        next_reqFlags = reqFlags;
        if (wrPend & (wrIdx == KRA_IDX_IF0)) begin
            next_reqFlags[7:0] = wrByte;
        end
        if (wrPend & (wrIdx == KRA_IDX_IF1)) begin
            next_reqFlags[15:8] = wrByte;
        end
        if (acceptMask) begin
            next_reqFlags[pickIdx] = 1'b0;
        end
        next_reqFlags = next_reqFlags | setVec;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reqFlags <= {KRA_RST_FLAGS, KRA_RST_FLAGS};
        end else begin
            reqFlags <= next_reqFlags;
        end
    end

    // mask reset to all ones: every source disabled until software opens it
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            maskFlags <= {KRA_RST_MASK, KRA_RST_MASK};
        end else if (wrPend & (wrIdx == KRA_IDX_MK0)) begin
            maskFlags[7:0] <= wrByte;
        end else if (wrPend & (wrIdx == KRA_IDX_MK1)) begin
            maskFlags[15:8] <= wrByte;
        end
    end

    // priority flag 1 puts a source in the low group
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prioFlags <= {KRA_RST_PRIO, KRA_RST_PRIO};
        end else if (wrPend & (wrIdx == KRA_IDX_PR0)) begin
            prioFlags[7:0] <= wrByte;
        end else if (wrPend & (wrIdx == KRA_IDX_PR1)) begin
            prioFlags[15:8] <= wrByte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word with the global enable in its top bit

    assign globalEnable = programStatusWord[KRA_PSW_IE];

    // acceptance is last so it always leaves the enable cleared
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            programStatusWord <= KRA_RST_PSW;
        end else begin
            if (wrPend & (wrIdx == KRA_IDX_PSW)) begin
                programStatusWord <= (wrByte & KRA_PSW_WMASK) | KRA_PSW_FIXED;
            end
            if (returnFromService) begin
                programStatusWord <= (restorePsw & KRA_PSW_WMASK) |
                                     KRA_PSW_FIXED;
            end
            if (enableInstr) begin
                programStatusWord[KRA_PSW_IE] <= 1'b1;
            end
            if (disableInstr) begin
                programStatusWord[KRA_PSW_IE] <= 1'b0;
            end
            if (acceptNmi | acceptMask) begin
                programStatusWord[KRA_PSW_IE] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acceptance

    // sticky until taken; a fresh one during service still gets through
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            nmiPending <= 1'b0;
        end else if (nmiRequest) begin
            nmiPending <= 1'b1;
        end else if (acceptNmi) begin
            nmiPending <= 1'b0;
        end
    end

    assign pendMask = reqFlags & ~maskFlags;

    kra_prio_pick u_prio_pick (
        .pending (pendMask),
        .lowPrio (prioFlags),
        .found   (found),
        .index   (pickIdx)
    );

    // flags are sampled in the last clock, so a set in that clock slips
    // one instruction; flag or mask access blocks the whole boundary
    assign acceptWindow = instrLastClock & ~instrFlagAccess &
                          ~flagRegWrite &
                          (state == KRA_ST_IDLE);
    assign acceptNmi  = acceptWindow & nmiPending;
    assign acceptMask = acceptWindow & ~nmiPending & found &
                        globalEnable;

    ////////////////////////////////////////////////////////////////////////
    // service sequence: status word, program counter, vector

    always_comb begin
        next_state = state;
        unique case (state)
            KRA_ST_IDLE: if (acceptNmi | acceptMask) begin
                next_state = KRA_ST_PSW;
            end
            KRA_ST_PSW: next_state = KRA_ST_PC;
            KRA_ST_PC:  next_state = KRA_ST_VEC;
            KRA_ST_VEC: next_state = KRA_ST_IDLE;
            default:    next_state = KRA_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state <= KRA_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // status word is captured before the enable drops
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            savedPsw  <= KRA_RST_PSW;
            vecTarget <= KRA_VEC_NMI;
        end else if (acceptNmi) begin
            savedPsw  <= programStatusWord;
            vecTarget <= KRA_VEC_NMI;
        end else if (acceptMask) begin
            savedPsw  <= programStatusWord;
            vecTarget <= KRA_VEC_BASE + {11'h000, pickIdx, 1'b0};
        end
    end

    // outputs trail the state by one cycle so each comes from a flop
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            stackPush  <= 1'b0;
            stackData  <= 16'h0000;
            vectorLoad <= 1'b0;
            vectorAddr <= 16'h0000;
        end else begin
            stackPush  <= (state == KRA_ST_PSW) | (state == KRA_ST_PC);
            vectorLoad <= (state == KRA_ST_VEC);
            if (state == KRA_ST_PSW) begin
                stackData <= {8'h00, savedPsw};
            end else if (state == KRA_ST_PC) begin
                stackData <= cpuPc;
            end
            if (state == KRA_ST_VEC) begin
                vectorAddr <= vecTarget;
            end
        end
    end

endmodule
`default_nettype wire

// [test/kra_key_intc_properties.sv]
`default_nettype none
module kra_key_intc_properties
    import kra_pkg::*;
(
    input wire logic                sys_clk,
    input wire logic                resetn,
    input wire logic                hreadyout,
    input wire logic                hresp,
    input wire logic [31:0]         hrdata,
    input wire logic [KRA_NKEY-1:0] portOutputMode,
    input wire logic [KRA_NKEY-1:0] keyPullUp,
    input wire logic                instrLastClock,
    input wire logic                instrFlagAccess,
    input wire logic [15:0]         cpuPc,
    input wire logic                stackPush,
    input wire logic [15:0]         stackData,
    input wire logic                vectorLoad,
    input wire logic [15:0]         vectorAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    // bus answers at once and only ever with okay
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus not ready");
    property p_rdata_byte;
        (hrdata >> 8) == 32'h0000_0000;
    endproperty
    a_rdata_byte: assert property (p_rdata_byte) else $error("upper bits");
    // service walk: two pushes, then one vector pulse
    property p_push_pair;
        $rose(stackPush) |=> stackPush ##1 (!stackPush && vectorLoad)
            ##1 !vectorLoad;
    endproperty
    a_push_pair: assert property (p_push_pair)
        else $error("push sequence");
    // acceptance only at an instruction end not touching flags
    property p_accept_gate;
        $rose(stackPush) |-> $past(instrLastClock, 2)
            && !$past(instrFlagAccess, 2);
    endproperty
    a_accept_gate: assert property (p_accept_gate)
        else $error("accept outside instruction end");
    property p_psw_save;
        $rose(stackPush) |-> stackData[15:8] == 8'h00 && stackData[1]
            && (stackData[7:0] & 8'h2C) == 8'h00;
    endproperty
    a_psw_save: assert property (p_psw_save)
        else $error("status word push");
    property p_pc_save;
        $rose(stackPush) |=> stackData == $past(cpuPc);
    endproperty
    a_pc_save: assert property (p_pc_save)
        else $error("pc push");
    property p_vector;
        vectorLoad |-> vectorAddr == KRA_VEC_NMI || (vectorAddr >= 16'h0004
            && vectorAddr <= 16'h0022 && !vectorAddr[0]);
    endproperty
    a_vector: assert property (p_vector) else $error("vector");
    // pull-up follows select one cycle late, never on an output pin
    property p_pullup_out;
        (keyPullUp & $past(portOutputMode)) == 6'h00;
    endproperty
    a_pullup_out: assert property (p_pullup_out)
        else $error("pull-up on output");
    property p_pull_group;
        keyPullUp[3:0] == 4'h0 || keyPullUp[3:0] == ~$past(portOutputMode[3:0]);
    endproperty
    a_pull_group: assert property (p_pull_group)
        else $error("group split");
    c_nmi: cover property (vectorLoad && vectorAddr == KRA_VEC_NMI);
    c_mask: cover property (vectorLoad && vectorAddr != KRA_VEC_NMI);
    c_pull: cover property (keyPullUp != 6'h00);
endmodule
bind kra_key_intc kra_key_intc_properties kra_key_intc_properties_inst (
    .sys_clk(sys_clk), .resetn(resetn), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .portOutputMode(portOutputMode),
    .keyPullUp(keyPullUp), .instrLastClock(instrLastClock),
    .instrFlagAccess(instrFlagAccess), .cpuPc(cpuPc),
    .stackPush(stackPush), .stackData(stackData),
    .vectorLoad(vectorLoad), .vectorAddr(vectorAddr));
`default_nettype wire

// [test/kra_cpu_model.sv]
`default_nettype none
module kra_cpu_model
    import kra_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   resetn,
    output logic        instrLastClock,
    output logic [15:0] cpuPc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    // four-clock instructions, so a request is seen before the last clock
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            phase <= 2'h0;
            cpuPc <= 16'h0100;
        end else begin
            phase <= phase + 2'h1;
            if (phase == 2'h3) cpuPc <= cpuPc + 16'h0001;
        end
    end
    assign instrLastClock = resetn && phase == 2'h3;
endmodule
`default_nettype wire

// [test/kra_key_intc_bench.sv]
`default_nettype none
module kra_key_intc_bench
    import kra_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, resetn, hwrite, hreadyout, hresp, nmiRequest;
    logic        instrLastClock, instrFlagAccess, enableInstr;
    logic        stackPush, vectorLoad, returnFromService;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [5:0]  keyInput, portOutputMode, keyPullUp;
    logic [15:0] periphRequest, cpuPc, stackData, vectorAddr;
    int          errors, nTests, cyc;
    kra_key_intc kra_key_intc_inst (.sys_clk(sys_clk), .resetn(resetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .keyInput(keyInput), .portOutputMode(portOutputMode),
        .keyPullUp(keyPullUp), .periphRequest(periphRequest),
        .nmiRequest(nmiRequest), .instrLastClock(instrLastClock),
        .instrFlagAccess(instrFlagAccess), .enableInstr(enableInstr),
        .disableInstr(1'b0), .returnFromService(returnFromService),
        .restorePsw(8'h82), .cpuPc(cpuPc), .stackPush(stackPush),
        .stackData(stackData), .vectorLoad(vectorLoad),
        .vectorAddr(vectorAddr));
    kra_cpu_model kra_cpu_model_inst (.sys_clk(sys_clk), .resetn(resetn),
        .instrLastClock(instrLastClock), .cpuPc(cpuPc));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one single transfer; the address phase is held until ready
    task automatic xfer(input logic [15:0] idx, input logic wr,
                        input logic [7:0] d);
        haddr <= {14'h0000, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= 32'(d);
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] e);
        xfer(idx, 1'b0, 8'h00);
        chk(rdv, 32'(e));
    endtask
    // one-cycle pulses of request, non-maskable request and enable
    task automatic go(input logic [15:0] v, input logic n, input logic e);
        periphRequest <= v;
        nmiRequest <= n;
        enableInstr <= e;
        @(posedge sys_clk);
        periphRequest <= 16'h0000;
        nmiRequest <= 1'b0;
        enableInstr <= 1'b0;
    endtask
    // wait no longer than the longest service latency, so a lost
    // or late request shows up as a mismatch instead of a hang
    task automatic waitvec(input logic [15:0] e);
        for (int i = 0; i < 19 && vectorLoad !== 1'b1; i++)
            @(posedge sys_clk);
        chk({15'h0000, vectorLoad, vectorAddr}, {16'h0001, e});
        @(posedge sys_clk);
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            chk(32'(vectorLoad), 32'h0000_0000);
        end
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", nTests, errors);
        if (errors == 0 && nTests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {resetn, hwrite, nmiRequest, instrFlagAccess, enableInstr} = 5'h00;
        {htrans, haddr, hwdata, periphRequest} = '0;
        keyInput = 6'h3F;
        portOutputMode = 6'h00;
        returnFromService = 1'b0;
        {errors, nTests, cyc} = '0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd(KRA_IDX_KRS, 8'h00);
        rd(KRA_IDX_PSW, 8'h02);
        rd(KRA_IDX_MK1, 8'hFF);
        rd(16'h0100, 8'h00);
        xfer(KRA_IDX_KRS, 1'b1, 8'h31);
        rd(KRA_IDX_KRS, 8'h31);
        portOutputMode <= 6'h21;
        repeat (3) @(posedge sys_clk);
        chk(32'(keyPullUp), 32'h0000_001E);
        keyInput <= 6'h2F;
        repeat (8) @(posedge sys_clk);
        rd(KRA_IDX_IF1, 8'h20);
        xfer(KRA_IDX_IF1, 1'b1, 8'h00);
        keyInput <= 6'h2E;
        repeat (8) @(posedge sys_clk);
        rd(KRA_IDX_IF1, 8'h00);
        keyInput <= 6'h3F;
        xfer(KRA_IDX_MK0, 1'b1, 8'hFE);
        xfer(KRA_IDX_PSW, 1'b1, 8'h80);
        go(16'h0001, 1'b0, 1'b0);
        waitvec(KRA_VEC_BASE);
        rd(KRA_IDX_IF0, 8'h00);
        rd(KRA_IDX_PSW, 8'h02);
        xfer(KRA_IDX_MK0, 1'b1, 8'hFC);
        go(16'h0002, 1'b0, 1'b0);
        quiet(20);
        go(16'h0000, 1'b0, 1'b1);
        waitvec(16'h0006);
        xfer(KRA_IDX_PR0, 1'b1, 8'hFB);
        xfer(KRA_IDX_MK0, 1'b1, 8'hFA);
        go(16'h0005, 1'b0, 1'b1);
        waitvec(16'h0008);
        go(16'h0000, 1'b0, 1'b1);
        waitvec(KRA_VEC_BASE);
        instrFlagAccess <= 1'b1;
        go(16'h0001, 1'b0, 1'b1);
        quiet(20);
        instrFlagAccess <= 1'b0;
        waitvec(KRA_VEC_BASE);
        go(16'h0001, 1'b1, 1'b1);
        waitvec(KRA_VEC_NMI);
        go(16'h0000, 1'b0, 1'b1);
        waitvec(KRA_VEC_BASE);
        go(16'h0000, 1'b1, 1'b0);
        waitvec(KRA_VEC_NMI);
        // return loads restorePsw, tied to 8'h82 here, enable included
        returnFromService <= 1'b1;
        @(posedge sys_clk);
        returnFromService <= 1'b0;
        rd(KRA_IDX_PSW, 8'h82);
        conclude();
    end
endmodule
`default_nettype wire
